// >>> rtl/periodic_wake_unit.sv
/*
  Periodic wakeup unit: counts a selected slow clock while the chip is
  stopped, latches a wakeup request on overflow and merges it with
  the keypad request into one pending flag and one keypad interrupt.
  Assumes stop_mode, wait_mode and kbd_pin_req come from logic on clk;
  the two counter clocks are asynchronous and much slower than clk.
*/
// The implementer's own choices: the plain strobed port and the register addresses.
// Functional notes
// - Generate periodic wakeups in stop from own counter, no pin.
// - Entering stop enables the wakeup generation.
// - Counter idle in run mode, runs only after stop entry.
// - Unit fully inactive in wait mode, no requests; the code stops only the counter, keypad pin requests still set pending.
// - Counter restarts from zero at every stop entry.
// - Overflow raises request, latched and passed to keypad logic.
// - Latch captures only when request is 1 and enable set.
// - Latch readable as read-only bit 6 of port A data register.
// - Clock is RC oscillator, or doubled bus clock if bit set.
// - Period select 1 gives short period, 0 gives long.
// - Latch cleared by keypad acknowledge write and by reset.
// - Interrupt enable does not change latch read value.
// - Request serviced only if enabled, through shared keypad vector.
// - Requests leave stop only while keypad mask is clear.
// - Short period 512 counter clocks, long 16,384.
// - Writing acknowledge 1 clears pending; bit reads as 0.
// - Pending flag set when keypad or wakeup pending; reset clears.
// - Mask 1 blocks keypad and wakeup interrupts; reset clears.
`timescale 1ns/1ps
module periodic_wake_unit
  import wake_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              stop_mode,
  input  wire logic              wait_mode,
  input  wire logic              wake_rc_oscillator,
  input  wire logic              double_bus_clock,
  input  wire logic              kbd_pin_req,
  output logic                   keypad_irq,
  output logic                   irq
);

  //////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    wake_state_e       st;
    logic              rc_d;
    logic              bus_d;
    logic              wake_latch;
    logic              kbd_pend;
    logic              mask;
    logic              wake_ie;
    logic              period_sel;
    logic              osc_stop;
    logic [EV_W-1:0]   irq_st;
    logic [EV_W-1:0]   irq_msk;
    logic [DATA_W-1:0] rdata;
  } unit_s;

  localparam unit_s UNIT_RST = '{st: ST_IDLE, default: '0};

  unit_s           s_r;
  unit_s           s_nxt;
  logic            rc_s;
  logic            bus_s;
  logic            ack;
  logic            wake_set;
  logic            pending;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;

  wake_ctr_if cif ();

  //////////////////////////////////////////////////////////////////////
  // Counter clock sampling and period counter

  // Slow clocks are asynchronous: sample twice before edge detection
  wake_sync #(
    .W (2)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({double_bus_clock, wake_rc_oscillator}),
    .q       ({bus_s, rc_s})
  );

  wake_counter u_counter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cif     (cif)
  );

  // Rising edges of the selected slow clock drive the count
  assign cif.tick = s_r.osc_stop ? (bus_s && !s_r.bus_d)
                                 : (rc_s && !s_r.rc_d);
  assign cif.run       = s_r.st == ST_RUN;
  assign cif.restart   = s_r.st == ST_IDLE;
  assign cif.short_sel = s_r.period_sel;

  //////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt       = s_r;
    s_nxt.rc_d  = rc_s;
    s_nxt.bus_d = bus_s;
    s_nxt.rdata = '0;
    ack         = wr_en && addr == ADDR_KEY_SC && wdata[BIT_ACK];
    wake_set    = cif.overflow && s_r.wake_ie;
    pending     = s_r.wake_latch || s_r.kbd_pend;
    ev          = '0;
    ev[EV_OVF]  = cif.overflow;
    ev[EV_CAP]  = wake_set;
    clr         = (wr_en && addr == ADDR_IRQ_ST) ? wdata[EV_W-1:0] : '0;

    // Sequencer: counts only in stop, never in wait
    case (s_r.st)
      ST_IDLE: begin
        if (stop_mode && !wait_mode) begin
          s_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!stop_mode || wait_mode) begin
          s_nxt.st = ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // Acknowledge clears, a new request in the same cycle wins
    if (ack) begin
      s_nxt.wake_latch = 1'b0;
      s_nxt.kbd_pend   = 1'b0;
    end
    if (wake_set) begin
      s_nxt.wake_latch = 1'b1;
    end
    if (kbd_pin_req) begin
      s_nxt.kbd_pend = 1'b1;
    end

    if (wr_en) begin
      case (addr)
        ADDR_KEY_SC:  s_nxt.mask       = wdata[BIT_MASK];
        ADDR_KEY_IE:  s_nxt.wake_ie    = wdata[BIT_WAKE_IE];
        ADDR_OPT_ONE: s_nxt.period_sel = wdata[BIT_PERIOD];
        ADDR_OPT_TWO: s_nxt.osc_stop   = wdata[BIT_OSC_STOP];
        ADDR_IRQ_MSK: s_nxt.irq_msk    = wdata[EV_W-1:0];
        default: ;
      endcase
    end

    // Status set wins over a write-one-to-clear in the same cycle
    s_nxt.irq_st = (s_r.irq_st & ~clr) | ev;

    // Read data; unmapped indices and write-only bits read as zero
    if (rd_en) begin
      case (addr)
        ADDR_PORT_A: begin
          // Latch reads back its own state whatever the interrupt enable says
          s_nxt.rdata[BIT_WAKE_LATCH] = s_r.wake_latch;
        end
        ADDR_KEY_SC: begin
          s_nxt.rdata[BIT_PEND] = pending;
          s_nxt.rdata[BIT_MASK] = s_r.mask;
        end
        ADDR_KEY_IE:  s_nxt.rdata[BIT_WAKE_IE]  = s_r.wake_ie;
        ADDR_OPT_ONE: s_nxt.rdata[BIT_PERIOD]   = s_r.period_sel;
        ADDR_OPT_TWO: s_nxt.rdata[BIT_OSC_STOP] = s_r.osc_stop;
        ADDR_IRQ_ST:  s_nxt.rdata[EV_W-1:0]     = s_r.irq_st;
        ADDR_IRQ_MSK: s_nxt.rdata[EV_W-1:0]     = s_r.irq_msk;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= UNIT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  // Shared keypad vector request, also the stop exit request
  assign keypad_irq = (s_r.wake_latch || s_r.kbd_pend) && !s_r.mask;
  assign irq        = |(s_r.irq_st & s_r.irq_msk);
  assign rdata      = s_r.rdata;

  //////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_stop_entry;
    s_r.st == ST_IDLE && stop_mode && !wait_mode;
  endsequence

  sequence s_wake_capture;
    cif.overflow && s_r.wake_ie;
  endsequence

  a_stop_enable: assert property (
    s_stop_entry |=> cif.run && !cif.restart)
    else $error("stop entry did not start the counter");

  a_wait_quiet: assert property (
    wait_mode |=> !cif.run ##1 !cif.overflow)
    else $error("counter active in wait mode");

  a_run_halt: assert property (
    !stop_mode |=> cif.restart)
    else $error("counter running outside stop");

  a_latch_set: assert property (
    s_wake_capture |=> s_r.wake_latch ##0 keypad_irq || s_r.mask)
    else $error("overflow not latched");

  a_latch_gate: assert property (
    !s_r.wake_latch && !s_r.wake_ie |=> !s_r.wake_latch)
    else $error("latch set while disabled");

  a_ack_clear: assert property (
    ack && !cif.overflow && !kbd_pin_req |=> !s_r.wake_latch
      && !s_r.kbd_pend && !keypad_irq)
    else $error("acknowledge did not clear pending");

  a_read_latch: assert property (
    rd_en && addr == ADDR_PORT_A
      |=> rdata[BIT_WAKE_LATCH] == $past(s_r.wake_latch))
    else $error("latch read value wrong");

  a_ack_reads: assert property (
    rd_en && addr == ADDR_KEY_SC |=> !rdata[BIT_ACK]
      && rdata[BIT_PEND] == $past(pending))
    else $error("status read wrong");

  a_mask_block: assert property (
    s_r.mask |-> !keypad_irq)
    else $error("masked request reached interrupt");

  // Mode, clock source and status checks

  a_run_idle: assert property (
    !stop_mode |=> !cif.run ##1 !cif.overflow)
    else $error("counter active in run mode");

  a_ovf_in_stop: assert property (
    cif.overflow |-> $past(cif.run) && $past(stop_mode && !wait_mode, 2))
    else $error("overflow outside stop");

  a_rc_ignored: assert property (
    s_r.osc_stop && !(bus_s && !s_r.bus_d) |-> !cif.tick)
    else $error("tick taken from unselected clock");

  a_bus_ignored: assert property (
    !s_r.osc_stop && !(rc_s && !s_r.rc_d) |-> !cif.tick)
    else $error("tick taken from unselected clock");

  a_osc_write: assert property (
    wr_en && addr == ADDR_OPT_TWO
      |=> s_r.osc_stop == $past(wdata[BIT_OSC_STOP]))
    else $error("clock source select not stored");

  a_period_write: assert property (
    wr_en && addr == ADDR_OPT_ONE
      |=> cif.short_sel == $past(wdata[BIT_PERIOD]))
    else $error("period select not stored");

  a_ie_gate: assert property (
    $rose(s_r.wake_latch) |-> $past(cif.overflow && s_r.wake_ie))
    else $error("latch set without enabled overflow");

  a_latch_hold: assert property (
    s_r.wake_latch && !ack |=> s_r.wake_latch)
    else $error("latch lost without acknowledge");

  a_pin_pend: assert property (
    kbd_pin_req
      |=> s_r.kbd_pend && (keypad_irq || s_r.mask))
    else $error("pin request not pending");

  a_status_set: assert property (
    cif.overflow |=> s_r.irq_st[EV_OVF]
      && (irq || !s_r.irq_msk[EV_OVF]))
    else $error("overflow status not raised");

  a_capture_status: assert property (
    s_wake_capture |=> s_r.irq_st[EV_CAP])
    else $error("capture status not raised");

endmodule : periodic_wake_unit

// >>> rtl/wake_counter.sv
/*
  Wakeup period counter: counts ticks while running and gives a one
  cycle overflow pulse at the end of the selected period.
  Assumes tick is a one cycle pulse on clk.
*/
`timescale 1ns/1ps
module wake_counter
  import wake_pkg::*;
#(
  parameter int SHORT = SHORT_PERIOD,
  parameter int LONG  = LONG_PERIOD,
  parameter int W     = CNT_W
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  wake_ctr_if.ctr   cif
);
  typedef struct packed {
    logic [W-1:0] count;
    logic         ovf;
  } ctr_s;

  ctr_s         s_r;
  ctr_s         s_nxt;
  logic [W-1:0] last;

  assign last = cif.short_sel ? W'(SHORT - 1) : W'(LONG - 1);

  always_comb begin
    s_nxt     = s_r;
    s_nxt.ovf = 1'b0;
    if (cif.restart) begin
      s_nxt.count = '0;
    end else if (cif.run && cif.tick) begin
      if (s_r.count >= last) begin
        s_nxt.count = '0;
        s_nxt.ovf   = 1'b1;
      end else begin
        s_nxt.count = s_r.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cif.overflow = s_r.ovf;

  sequence s_final_tick;
    cif.run && !cif.restart && cif.tick && s_r.count == last;
  endsequence

  a_period_end: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_final_tick |=> cif.overflow && s_r.count == '0)
    else $error("overflow missing at end of period");

  a_restart_zero: assert property (
    @(posedge clk) disable iff (sys_rst)
    cif.restart |=> s_r.count == '0 && !cif.overflow)
    else $error("counter not held at zero");
endmodule : wake_counter

// >>> rtl/wake_ctr_if.sv
/*
  Interface between the wakeup sequencer and its period counter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface wake_ctr_if;
  logic tick;
  logic run;
  logic restart;
  logic short_sel;
  logic overflow;

  modport ctl (output tick, output run, output restart,
               output short_sel, input overflow);
  modport ctr (input tick, input run, input restart,
               input short_sel, output overflow);
endinterface : wake_ctr_if

// >>> rtl/wake_pkg.sv
/*
  Shared constants for the stop mode wakeup timer: register indices,
  field positions, wakeup periods and the sequencer state type.
  Assumes an 8-bit register port with a 3-bit word index.
*/
package wake_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register indices
  localparam logic [ADDR_W-1:0] ADDR_PORT_A  = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_KEY_SC  = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_KEY_IE  = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_OPT_ONE = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_OPT_TWO = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ST  = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MSK = 3'h6;

  // Field positions
  localparam int BIT_WAKE_LATCH = 6;
  localparam int BIT_PEND       = 3;
  localparam int BIT_ACK        = 2;
  localparam int BIT_MASK       = 1;
  localparam int BIT_WAKE_IE    = 6;
  localparam int BIT_PERIOD     = 7;
  localparam int BIT_OSC_STOP   = 1;

  // Interrupt status events
  localparam int EV_OVF = 0;
  localparam int EV_CAP = 1;
  localparam int EV_W   = 2;

  // Wakeup periods in counter clock cycles
  localparam int SHORT_PERIOD = 512;
  localparam int LONG_PERIOD  = 16384;
  localparam int CNT_W        = 14;

  typedef enum logic [0:0] {ST_IDLE, ST_RUN} wake_state_e;

endpackage : wake_pkg

// >>> rtl/wake_sync.sv
/*
  Two flip-flop synchroniser for a bundle of asynchronous levels.
  Assumes each bit changes slowly compared with clk.
*/
`timescale 1ns/1ps
module wake_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } sync_s;

  sync_s s_r;
  sync_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = d;
    s_nxt.held = s_r.meta;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.held;
endmodule : wake_sync

// >>> tb/cpu_mode_model.sv
/*
  Power mode model of the CPU side: enters stop when asked, leaves it
  on a keypad interrupt or when told to. Assumes one-cycle pulses.
*/
`timescale 1ns/1ps
module cpu_mode_model (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic go_stop,
  input  wire logic go_run,
  input  wire logic keypad_irq,
  output logic      stop_mode
);
  // Keypad vector taken as the wake event out of stop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      stop_mode <= 1'b0;
    else if (go_stop)
      stop_mode <= 1'b1;
    else if (go_run || keypad_irq)
      stop_mode <= 1'b0;
  end
endmodule : cpu_mode_model

// >>> tb/periodic_wake_unit_test.sv
/*
  Self-checking bench for the stop mode wakeup timer.
  Assumes the top uses the default periods of 512 and 16384 ticks.
*/
`timescale 1ns/1ps
module periodic_wake_unit_test;
  import wake_pkg::*;
  logic              clk, sys_rst, wr_en, rd_en, wait_mode, kbd_pin_req;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic              stop_mode, rc, bus2, bus_on, keypad_irq, irq;
  logic              go_stop, go_run;
  int                error_cnt, checks_done, n;

  periodic_wake_unit DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .stop_mode(stop_mode), .wait_mode(wait_mode),
    .wake_rc_oscillator(rc), .double_bus_clock(bus2),
    .kbd_pin_req(kbd_pin_req), .keypad_irq(keypad_irq), .irq(irq));
  cpu_mode_model cpu (.clk(clk), .sys_rst(sys_rst), .go_stop(go_stop),
    .go_run(go_run), .keypad_irq(keypad_irq), .stop_mode(stop_mode));

  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Slow clocks: 6 and 7 bus cycles per period
  initial begin
    rc = 1'b0;
    forever #120 rc = ~rc;
  end
  initial begin
    bus2 = 1'b0;
    #10;
    forever #140 if (bus_on) bus2 = ~bus2;
  end

  task automatic chk(input logic [7:0] v, input logic [7:0] e);
    checks_done++;
    if (v !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  function automatic logic [7:0] near(input int v, input int c);
    return {7'h0, (v >= c - 12) && (v <= c + 12)};
  endfunction : near
  // Enter stop and count cycles until the keypad interrupt or lim
  task automatic stop_until(input int lim);
    @(posedge clk) go_stop <= 1'b1;
    @(posedge clk) go_stop <= 1'b0;
    n = 0;
    while (keypad_irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : stop_until
  task automatic run_now;
    @(posedge clk) go_run <= 1'b1;
    @(posedge clk) go_run <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : run_now
  task automatic ack;
    wr(ADDR_KEY_SC, 8'h04);
    wr(ADDR_IRQ_ST, 8'h03);
  endtask : ack
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(ADDR_PORT_A); chk(d, 8'h00);
    rd(ADDR_KEY_SC); chk(d, 8'h00);
    rd(ADDR_KEY_IE); chk(d, 8'h00);
    rd(3'h7); chk(d, 8'h00);
    $display("reset values done");
  endtask : t_reset
  task automatic t_idle;
    repeat (3300) @(posedge clk);
    rd(ADDR_IRQ_ST); chk(d, 8'h00);
    wait_mode <= 1'b1;
    stop_until(3300);
    chk(keypad_irq, 1'b0);
    rd(ADDR_IRQ_ST); chk(d, 8'h00);
    run_now;
    wait_mode <= 1'b0;
    $display("run and wait idle done");
  endtask : t_idle
  task automatic t_short;
    stop_until(4000);
    chk(near(n, 512 * 6), 8'h01);
    repeat (3) @(posedge clk);
    chk(stop_mode, 1'b0);
    rd(ADDR_PORT_A); chk(d, 8'h40);
    rd(ADDR_KEY_SC); chk(d, 8'h08);
    rd(ADDR_IRQ_ST); chk(d, 8'h03);
    wr(ADDR_KEY_IE, 8'h00);
    rd(ADDR_PORT_A); chk(d, 8'h40);
    wr(ADDR_KEY_IE, 8'h40);
    wr(ADDR_KEY_SC, 8'h04);
    rd(ADDR_PORT_A); chk(d, 8'h00);
    rd(ADDR_KEY_SC); chk(d, 8'h00);
    chk(keypad_irq, 1'b0);
    ack;
    $display("short period done");
  endtask : t_short
  task automatic t_disabled;
    wr(ADDR_IRQ_MSK, 8'h01);
    wr(ADDR_KEY_IE, 8'h00);
    stop_until(3300);
    chk(keypad_irq, 1'b0);
    rd(ADDR_PORT_A); chk(d, 8'h00);
    rd(ADDR_IRQ_ST); chk(d, 8'h01);
    chk(irq, 1'b1);
    run_now;
    wr(ADDR_IRQ_ST, 8'h01);
    #1 chk(irq, 1'b0);
    wr(ADDR_IRQ_MSK, 8'h00);
    wr(ADDR_KEY_IE, 8'h40);
    $display("enable off done");
  endtask : t_disabled
  task automatic t_mask;
    wr(ADDR_KEY_SC, 8'h02);
    stop_until(3300);
    chk(keypad_irq, 1'b0);
    chk(stop_mode, 1'b1);
    rd(ADDR_PORT_A); chk(d, 8'h40);
    rd(ADDR_KEY_SC); chk(d, 8'h0a);
    run_now;
    ack;
    $display("mask done");
  endtask : t_mask
  task automatic t_bus_clock;
    wr(ADDR_OPT_TWO, 8'h02);
    bus_on = 1'b1;
    stop_until(4000);
    chk(near(n, 512 * 7), 8'h01);
    bus_on = 1'b0;
    wr(ADDR_OPT_TWO, 8'h00);
    ack;
    $display("bus clock done");
  endtask : t_bus_clock
  task automatic t_restart;
    stop_until(1500);
    run_now;
    stop_until(4000);
    chk(near(n, 512 * 6), 8'h01);
    ack;
    $display("restart done");
  endtask : t_restart
  task automatic t_long;
    wr(ADDR_OPT_ONE, 8'h00);
    stop_until(4000);
    chk(keypad_irq, 1'b0);
    rd(ADDR_IRQ_ST); chk(d, 8'h00);
    run_now;
    wr(ADDR_OPT_ONE, 8'h80);
    $display("long period done");
  endtask : t_long
  task automatic t_pin;
    @(posedge clk) kbd_pin_req <= 1'b1;
    @(posedge clk) kbd_pin_req <= 1'b0;
    rd(ADDR_KEY_SC); chk(d, 8'h08);
    chk(keypad_irq, 1'b1);
    ack;
    rd(ADDR_KEY_SC); chk(d, 8'h00);
    $display("keypad pin done");
  endtask : t_pin

  //////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    error_cnt = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    {wr_en, rd_en, wait_mode, kbd_pin_req, bus_on} = '0;
    {go_stop, go_run, addr, wdata} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    wr(ADDR_KEY_IE, 8'h40);
    wr(ADDR_OPT_ONE, 8'h80);
    t_idle();
    t_short();
    t_disabled();
    t_mask();
    t_bus_clock();
    t_restart();
    t_long();
    t_pin();
    wrap_up();
  end
endmodule : periodic_wake_unit_test
